// File: design/rtcg_general_config.sv
// Real-time clock core around the general configuration register
//
// Notes on behaviour
// - Configuration register is 8 bits at index 0x0b, read and write.
// - Inhibit bit 7 clear: one time update per second; no reset touches it.
// - Setting inhibit aborts a pending update and stops updates until cleared.
// - Inhibit is a pure update gate and survives every reset.
// - Periodic enable bit 6 raises interrupt at the rate-select period.
// - Periodic, update-ended and square-wave enables cleared by resume reset only.
// - Alarm enable bit 5 raises interrupt when an update sets the alarm flag.
// - Alarm enable cleared only by the RTC-well reset.
// - Update-ended enable bit 4 raises interrupt at each update completion.
// - Square-wave enable bit 3 is storage only, drives nothing.
// - Bit 2 one selects binary, zero BCD; no reset changes it.
// - Bit 1 one selects 24-hour, zero 12-hour; no reset changes it.
// - In 12-hour mode hour bit 7 is the PM indicator.
// - Daylight saving: first April Sunday 1:59:59 AM jumps to 3:00:00.
// - Last October Sunday: first 1:59:59 AM goes back to 1:00:00, once.
// - Daylight saving disabled: no special hour changes.
// - Switch dates follow 1987 US law; enable survives every reset.
// - Interrupt request is OR of each flag ANDed with its enable.
// - Update-ended flag set after each update; cleared by read or resume reset.
// - Rate select zero produces no periodic events.
`timescale 1ns/1ps
module rtcg_general_config
  import rtcg_pkg::*;
#(
  parameter int CLK_HZ = 10000000
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Power-well reset pins, asynchronous, active low
  input  wire logic        resume_well_reset_n,
  input  wire logic        rtc_well_reset_n,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt output, active low
  output logic             rtc_irq_out_n
);

  localparam logic [31:0] CLK_W  = 32'(CLK_HZ);
  localparam logic [31:0] TICK_W = 32'(TICK_HZ);

  // ==========================================================
  // Encoding helpers
  function automatic logic [7:0] enc(input logic [7:0] v, input logic bin);
    enc = bin ? v : {4'(v / 8'd10), 4'(v % 8'd10)};
  endfunction

  function automatic logic [7:0] dec(input logic [7:0] d, input logic bin);
    dec = bin ? d : 8'(d[7:4] * 8'd10 + {4'h0, d[3:0]});
  endfunction

  function automatic logic [7:0] enc_hour(input logic [7:0] h,
                                          input logic bin,
                                          input logic h24);
    logic [7:0] h12;
    logic [7:0] e12;
    h12 = (h == 8'h00) ? HOUR_NOON : (h > HOUR_NOON) ? 8'(h - HOUR_NOON) : h;
    e12 = enc(h12, bin);
    if (h24) begin
      enc_hour = enc(h, bin);
    end else begin
      enc_hour = {h >= HOUR_NOON, e12[6:0]};
    end
  endfunction

  function automatic logic [7:0] dec_hour(input logic [7:0] d,
                                          input logic bin,
                                          input logic h24);
    logic [7:0] h12;
    h12 = dec({1'b0, d[6:0]}, bin);
    if (h24) begin
      dec_hour = dec(d, bin);
    end else begin
      dec_hour = 8'((h12 == HOUR_NOON ? 8'h00 : h12)
                    + (d[7] ? HOUR_NOON : 8'h00));
    end
  endfunction

  function automatic logic [7:0] days_in(input logic [7:0] m);
    case (m)
      8'h02:                      days_in = 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: days_in = 8'h1e;
      default:                    days_in = 8'h1f;
    endcase
  endfunction

  function automatic logic [DIV_BITS-1:0] tap_mask(input logic [3:0] rs);
    logic [3:0] n;
    n = (rs >= 4'h3) ? 4'(rs - 4'h1) : 4'(rs + 4'h6);
    tap_mask = DIV_BITS'((16'h1 << n) - 16'h1);
  endfunction

  function automatic logic amatch(input logic [7:0] a, input logic [7:0] v);
    amatch = (a[7:6] == ALARM_DC) || (a == v);
  endfunction

  // ==========================================================
  // State
  logic [2:0]          rsm_sync_r, rsm_sync_nxt;
  logic [2:0]          rtcw_sync_r, rtcw_sync_nxt;
  logic                rsm_lvl_r, rsm_lvl_nxt;
  logic                rtcw_lvl_r, rtcw_lvl_nxt;
  logic                pend_r, pend_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic [31:0]         acc_r, acc_nxt;
  logic [DIV_BITS-1:0] div_r, div_nxt;
  logic [7:0]          cfg_r, cfg_nxt;
  logic [3:0]          rate_r, rate_nxt;
  logic                pf_r, pf_nxt;
  logic                af_r, af_nxt;
  logic                uf_r, uf_nxt;
  logic [7:0]          sec_r, sec_nxt;
  logic [7:0]          min_r, min_nxt;
  logic [7:0]          hour_r, hour_nxt;
  logic [7:0]          wday_r, wday_nxt;
  logic [7:0]          date_r, date_nxt;
  logic [7:0]          mon_r, mon_nxt;
  logic [7:0]          asec_r, asec_nxt;
  logic [7:0]          amin_r, amin_nxt;
  logic [7:0]          ahour_r, ahour_nxt;
  logic                fell_r, fell_nxt;

  // Decoded strobes and helpers
  logic       req;
  logic       acc_rd;
  logic       wr;
  logic [5:0] idx;
  logic [7:0] wd;
  logic       tick;
  logic       sec_tick;
  logic       upd;
  logic       at_159;
  logic       irq_request_flag;
  logic [7:0] rd_byte;

  // ==========================================================
  // Bus handshake: one wait cycle, then accept
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~pend_r;
  assign avs_readdata    = rdata_r;
  assign idx             = avs_address[7:2];
  assign wd              = avs_writedata[7:0];

  // Interrupt request from flags and enables
  assign irq_request_flag = (pf_r & cfg_r[CFG_PIE]) | (af_r & cfg_r[CFG_AIE])
              | (uf_r & cfg_r[CFG_UIE]);
  assign rtc_irq_out_n = ~irq_request_flag;

  // ==========================================================
  // Next-state logic
  always_comb begin
    // Pin synchronisers; level changes once stages two and three agree
    rsm_sync_nxt  = {rsm_sync_r[1:0], resume_well_reset_n};
    rtcw_sync_nxt = {rtcw_sync_r[1:0], rtc_well_reset_n};
    rsm_lvl_nxt   = (rsm_sync_r[1] == rsm_sync_r[2]) ? rsm_sync_r[2]
                                                     : rsm_lvl_r;
    rtcw_lvl_nxt  = (rtcw_sync_r[1] == rtcw_sync_r[2]) ? rtcw_sync_r[2]
                                                       : rtcw_lvl_r;

    // Bus phase
    pend_nxt = req & ~pend_r;
    acc_rd   = avs_read & pend_r;
    wr       = avs_write & pend_r & avs_byteenable[0];

    // Read mux, captured in the wait cycle
    case (idx)
      IDX_SEC:   rd_byte = enc(sec_r, cfg_r[CFG_BIN]);
      IDX_MIN:   rd_byte = enc(min_r, cfg_r[CFG_BIN]);
      IDX_HOUR:  rd_byte = enc_hour(hour_r, cfg_r[CFG_BIN],
                                    cfg_r[CFG_H24]);
      IDX_WDAY:  rd_byte = enc(wday_r, cfg_r[CFG_BIN]);
      IDX_DATE:  rd_byte = enc(date_r, cfg_r[CFG_BIN]);
      IDX_MON:   rd_byte = enc(mon_r, cfg_r[CFG_BIN]);
      IDX_ASEC:  rd_byte = asec_r;
      IDX_AMIN:  rd_byte = amin_r;
      IDX_AHOUR: rd_byte = ahour_r;
      IDX_RATE:  rd_byte = {4'h0, rate_r};
      IDX_CFG:   rd_byte = cfg_r;
      IDX_FLAG:  rd_byte = {irq_request_flag, pf_r, af_r, uf_r, 4'h0};
      default:   rd_byte = 8'h00;
    endcase
    rdata_nxt = (avs_read & ~pend_r) ? {24'h0, rd_byte} : rdata_r;

    // Configuration and rate registers
    cfg_nxt  = (wr && idx == IDX_CFG) ? wd : cfg_r;
    rate_nxt = (wr && idx == IDX_RATE) ? wd[3:0] : rate_r;
    if (!rsm_lvl_r) begin
      cfg_nxt[CFG_PIE]  = 1'b0;
      cfg_nxt[CFG_UIE]  = 1'b0;
      cfg_nxt[CFG_SQUARE_WAVE_ENABLE] = 1'b0;
    end
    if (!rtcw_lvl_r) begin
      cfg_nxt[CFG_AIE] = 1'b0;
    end

    // 32768 Hz tick by phase accumulation, then divider chain
    acc_nxt = acc_r + TICK_W;
    tick    = 1'b0;
    if (acc_nxt >= CLK_W) begin
      acc_nxt = acc_nxt - CLK_W;
      tick    = 1'b1;
    end
    div_nxt  = tick ? DIV_BITS'(div_r + 1'b1) : div_r;
    sec_tick = tick && (div_nxt == '0);
    // Update gated by this cycle's inhibit value, so a write aborts it
    upd = sec_tick & ~cfg_nxt[CFG_INHIBIT];

    // Time counters: bus writes win over the update
    sec_nxt  = sec_r;
    min_nxt  = min_r;
    hour_nxt = hour_r;
    wday_nxt = wday_r;
    date_nxt = date_r;
    mon_nxt  = mon_r;
    fell_nxt = fell_r;
    at_159   = (hour_r == DST_HOUR) && (min_r == SEC_MAX)
            && (sec_r == SEC_MAX);
    if (wr && (idx == IDX_SEC || idx == IDX_MIN || idx == IDX_HOUR
        || idx == IDX_WDAY || idx == IDX_DATE || idx == IDX_MON)) begin
      case (idx)
        IDX_SEC:  sec_nxt  = dec(wd, cfg_r[CFG_BIN]);
        IDX_MIN:  min_nxt  = dec(wd, cfg_r[CFG_BIN]);
        IDX_HOUR: hour_nxt = dec_hour(wd, cfg_r[CFG_BIN], cfg_r[CFG_H24]);
        IDX_WDAY: wday_nxt = dec(wd, cfg_r[CFG_BIN]);
        IDX_DATE: date_nxt = dec(wd, cfg_r[CFG_BIN]);
        default:  mon_nxt  = dec(wd, cfg_r[CFG_BIN]);
      endcase
    end else if (upd) begin
      if (cfg_r[CFG_DSE] && at_159 && mon_r == MON_APRIL
          && wday_r == SUNDAY && date_r <= APR_LAST_D) begin
        sec_nxt  = 8'h00;
        min_nxt  = 8'h00;
        hour_nxt = DST_SKIP_TO;
      end else if (cfg_r[CFG_DSE] && at_159 && !fell_r
                   && mon_r == MON_OCTOBER && wday_r == SUNDAY
                   && date_r >= OCT_FIRST_D) begin
        sec_nxt  = 8'h00;
        min_nxt  = 8'h00;
        fell_nxt = 1'b1;
      end else if (sec_r < SEC_MAX) begin
        sec_nxt = 8'(sec_r + 8'h01);
      end else begin
        sec_nxt = 8'h00;
        if (min_r < SEC_MAX) begin
          min_nxt = 8'(min_r + 8'h01);
        end else begin
          min_nxt = 8'h00;
          if (hour_r < HOUR_MAX) begin
            hour_nxt = 8'(hour_r + 8'h01);
          end else begin
            hour_nxt = 8'h00;
            fell_nxt = 1'b0;
            wday_nxt = (wday_r >= DAYS_WEEK) ? SUNDAY : 8'(wday_r + 8'h01);
            if (date_r < days_in(mon_r)) begin
              date_nxt = 8'(date_r + 8'h01);
            end else begin
              date_nxt = 8'h01;
              mon_nxt  = (mon_r >= MONTHS) ? 8'h01 : 8'(mon_r + 8'h01);
            end
          end
        end
      end
    end

    // Alarm registers hold raw bytes in the software format
    asec_nxt  = (wr && idx == IDX_ASEC) ? wd : asec_r;
    amin_nxt  = (wr && idx == IDX_AMIN) ? wd : amin_r;
    ahour_nxt = (wr && idx == IDX_AHOUR) ? wd : ahour_r;

    // Flags: read clears only what was captured; new set wins
    pf_nxt = pf_r;
    af_nxt = af_r;
    uf_nxt = uf_r;
    if (acc_rd && idx == IDX_FLAG) begin
      pf_nxt = pf_r & ~rdata_r[FLG_PF];
      af_nxt = af_r & ~rdata_r[FLG_AF];
      uf_nxt = uf_r & ~rdata_r[FLG_UF];
    end
    if (tick && rate_r != 4'h0
        && (div_nxt & tap_mask(rate_r)) == '0) begin
      pf_nxt = 1'b1;
    end
    if (upd) begin
      uf_nxt = 1'b1;
      if (amatch(asec_r, enc(sec_nxt, cfg_r[CFG_BIN]))
          && amatch(amin_r, enc(min_nxt, cfg_r[CFG_BIN]))
          && amatch(ahour_r, enc_hour(hour_nxt, cfg_r[CFG_BIN],
                                      cfg_r[CFG_H24]))) begin
        af_nxt = 1'b1;
      end
    end
    if (!rsm_lvl_r) begin
      pf_nxt = 1'b0;
      uf_nxt = 1'b0;
    end
    if (!rtcw_lvl_r) begin
      af_nxt = 1'b0;
    end
  end

  // ==========================================================
  // Registers; configuration bits have no system reset
  always_ff @(posedge clk_sys) begin
    cfg_r <= cfg_nxt;
    if (sys_rst) begin
      rsm_sync_r  <= 3'h7;
      rtcw_sync_r <= 3'h7;
      rsm_lvl_r   <= 1'b1;
      rtcw_lvl_r  <= 1'b1;
      pend_r      <= 1'b0;
      rdata_r     <= 32'h0;
      acc_r       <= 32'h0;
      div_r       <= '0;
      rate_r      <= 4'h0;
      pf_r        <= 1'b0;
      af_r        <= 1'b0;
      uf_r        <= 1'b0;
      sec_r       <= 8'h00;
      min_r       <= 8'h00;
      hour_r      <= 8'h00;
      wday_r      <= 8'h01;
      date_r      <= 8'h01;
      mon_r       <= 8'h01;
      asec_r      <= 8'h00;
      amin_r      <= 8'h00;
      ahour_r     <= 8'h00;
      fell_r      <= 1'b0;
    end else begin
      rsm_sync_r  <= rsm_sync_nxt;
      rtcw_sync_r <= rtcw_sync_nxt;
      rsm_lvl_r   <= rsm_lvl_nxt;
      rtcw_lvl_r  <= rtcw_lvl_nxt;
      pend_r      <= pend_nxt;
      rdata_r     <= rdata_nxt;
      acc_r       <= acc_nxt;
      div_r       <= div_nxt;
      rate_r      <= rate_nxt;
      pf_r        <= pf_nxt;
      af_r        <= af_nxt;
      uf_r        <= uf_nxt;
      sec_r       <= sec_nxt;
      min_r       <= min_nxt;
      hour_r      <= hour_nxt;
      wday_r      <= wday_nxt;
      date_r      <= date_nxt;
      mon_r       <= mon_nxt;
      asec_r      <= asec_nxt;
      amin_r      <= amin_nxt;
      ahour_r     <= ahour_nxt;
      fell_r      <= fell_nxt;
    end
  end

endmodule

// File: design/rtcg_pkg.sv
// Constants for the real-time clock general configuration block
package rtcg_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_SEC   = 6'h00;
  localparam logic [5:0] IDX_ASEC  = 6'h01;
  localparam logic [5:0] IDX_MIN   = 6'h02;
  localparam logic [5:0] IDX_AMIN  = 6'h03;
  localparam logic [5:0] IDX_HOUR  = 6'h04;
  localparam logic [5:0] IDX_AHOUR = 6'h05;
  localparam logic [5:0] IDX_WDAY  = 6'h06;
  localparam logic [5:0] IDX_DATE  = 6'h07;
  localparam logic [5:0] IDX_MON   = 6'h08;
  localparam logic [5:0] IDX_RATE  = 6'h0a;
  localparam logic [5:0] IDX_CFG   = 6'h0b;
  localparam logic [5:0] IDX_FLAG  = 6'h0c;
  // ==========================================================
  // General configuration bit positions
  localparam int CFG_INHIBIT = 7;
  localparam int CFG_PIE     = 6;
  localparam int CFG_AIE     = 5;
  localparam int CFG_UIE     = 4;
  localparam int CFG_SQUARE_WAVE_ENABLE    = 3;
  localparam int CFG_BIN     = 2;
  localparam int CFG_H24     = 1;
  localparam int CFG_DSE     = 0;
  // ==========================================================
  // Flag register bit positions
  localparam int FLG_IRQ = 7;
  localparam int FLG_PF  = 6;
  localparam int FLG_AF  = 5;
  localparam int FLG_UF  = 4;
  // ==========================================================
  // Timebase and calendar constants
  localparam int         TICK_HZ     = 32768;
  localparam int         DIV_BITS    = 15;
  localparam logic [1:0] ALARM_DC    = 2'h3;
  localparam logic [7:0] SUNDAY      = 8'h01;
  localparam logic [7:0] DAYS_WEEK   = 8'h07;
  localparam logic [7:0] MON_APRIL   = 8'h04;
  localparam logic [7:0] MON_OCTOBER = 8'h0a;
  localparam logic [7:0] APR_LAST_D  = 8'h07;
  localparam logic [7:0] OCT_FIRST_D = 8'h19;
  localparam logic [7:0] MONTHS      = 8'h0c;
  localparam logic [7:0] SEC_MAX     = 8'h3b;
  localparam logic [7:0] HOUR_MAX    = 8'h17;
  localparam logic [7:0] HOUR_NOON   = 8'h0c;
  localparam logic [7:0] DST_HOUR    = 8'h01;
  localparam logic [7:0] DST_SKIP_TO = 8'h03;
endpackage

// File: verification/rtcg_general_config_properties.sv
// Port-level checks for the general configuration block
`timescale 1ns/1ps
module rtcg_general_config_properties
  import rtcg_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Well resets
  input wire logic        resume_well_reset_n,
  input wire logic        rtc_well_reset_n,
  // Register bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Interrupt
  input wire logic        rtc_irq_out_n
);
  // ==========================================================
  // Helper logic
  logic       acc;
  logic       cfg_wr;
  logic       cfg_rd;
  logic       flg_rd;
  logic       odd_rd;
  logic [7:0] shadow_r;
  logic       known_r;
  logic [3:0] quiet_r;
  logic [5:0] idx;
  assign idx    = avs_address[7:2];
  assign acc    = (avs_read | avs_write) & ~avs_waitrequest;
  assign cfg_wr = acc & avs_write & avs_byteenable[0] & (idx == IDX_CFG);
  assign cfg_rd = acc & avs_read & (idx == IDX_CFG);
  assign flg_rd = acc & avs_read & (idx == IDX_FLAG);
  assign odd_rd = acc & avs_read & ((idx == 6'h09) | (idx > IDX_FLAG));
  // Shadow of the configuration byte, cleared as the wells clear it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) known_r <= 1'b0;
    else if (cfg_wr) known_r <= 1'b1;
    if (cfg_wr) shadow_r <= avs_writedata[7:0];
    else shadow_r <= shadow_r & ~{1'b0, ~resume_well_reset_n,
      ~rtc_well_reset_n, {2{~resume_well_reset_n}}, 3'h0};
  end
  // Cycles since any reset, saturating
  always_ff @(posedge clk_sys) begin
    if (sys_rst | ~resume_well_reset_n | ~rtc_well_reset_n) quiet_r <= 4'h0;
    else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Assertions
  property p_wait_first;
    (avs_read | avs_write) && !$past(avs_read | avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("no wait cycle on new request");
  property p_wait_one;
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("more than one wait cycle");
  property p_wait_idle;
    !(avs_read | avs_write) |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest without request");
  property p_upper_zero;
    avs_readdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits set");
  property p_rd_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  property p_cfg_back;
    cfg_rd && known_r |-> avs_readdata[7:0] == shadow_r;
  endproperty
  a_cfg_back: assert property (p_cfg_back)
    else $error("configuration readback wrong");
  property p_unmapped;
    odd_rd |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_well_quiet;
    (!resume_well_reset_n && !rtc_well_reset_n) [*7] |-> rtc_irq_out_n;
  endproperty
  a_well_quiet: assert property (p_well_quiet)
    else $error("interrupt during well resets");
  property p_irq_cause;
    $rose(rtc_irq_out_n) |-> $past(flg_rd | cfg_wr) || quiet_r < 4'h8;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt released without cause");
endmodule

// File: verification/rtcg_general_config_tb_top.sv
// Self-checking bench for the general configuration block
`timescale 1ns/1ps
module rtcg_general_config_tb_top
  import rtcg_pkg::*;
;
  localparam logic [7:0] A_SEC  = {IDX_SEC, 2'b00};
  localparam logic [7:0] A_HOUR = {IDX_HOUR, 2'b00};
  localparam logic [7:0] A_RATE = {IDX_RATE, 2'b00};
  localparam logic [7:0] A_CFG  = {IDX_CFG, 2'b00};
  localparam logic [7:0] A_FLAG = {IDX_FLAG, 2'b00};
  localparam logic [7:0] A_MIN  = {IDX_MIN, 2'b00};
  localparam logic [7:0] A_WDAY = {IDX_WDAY, 2'b00};
  localparam logic [7:0] A_DATE = {IDX_DATE, 2'b00};
  localparam logic [7:0] A_MON  = {IDX_MON, 2'b00};
  localparam logic [7:0] A_ASEC = {IDX_ASEC, 2'b00};
  localparam logic [7:0] A_AHR  = {IDX_AHOUR, 2'b00};
  logic        clk_sys;
  logic        sys_rst;
  logic        resume_well_reset_n;
  logic        rtc_well_reset_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rtc_irq_out_n;
  logic [31:0] q;
  logic [7:0]  v;
  logic        hit;
  int          hrs [5] = '{0, 1, 12, 13, 23};
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  rtcg_general_config #(.CLK_HZ(32768)) DUT (
    .clk_sys, .sys_rst, .resume_well_reset_n, .rtc_well_reset_n,
    .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .rtc_irq_out_n
  );
  // Clock at 100 ns
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 99800) begin
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      test_done();
    end
  end
  // ==========================================================
  // Tasks and expectation functions
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [7:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_read <= rd;
    avs_write <= ~rd;
    avs_address <= a;
    avs_writedata <= {24'($urandom), d};
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b1, a, 8'h00, 4'h1);
    check(q, {24'h0, e});
  endtask
  // Well reset pins low for 8 cycles, then 8 quiet cycles
  task automatic pulse(input logic rs, input logic rt);
    @(posedge clk_sys);
    resume_well_reset_n <= ~rs;
    rtc_well_reset_n <= ~rt;
    repeat (8) @(posedge clk_sys);
    resume_well_reset_n <= 1'b1;
    rtc_well_reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic wait_irq(input int lim, input logic e);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge clk_sys);
      hit = (rtc_irq_out_n === e);
    end
  endtask
  function automatic logic [7:0] exp_well(input logic [7:0] c,
                                          input logic rs, input logic rt);
    logic [7:0] m;
    m = 8'h00;
    m[CFG_PIE] = rs;
    m[CFG_UIE] = rs;
    m[CFG_SQUARE_WAVE_ENABLE] = rs;
    m[CFG_AIE] = rt;
    return c & ~m;
  endfunction
  function automatic logic [7:0] exp_hour(input int h, input logic bin,
                                          input logic h24);
    int         x;
    logic [7:0] e;
    x = h24 ? h : ((h % 12 == 0) ? 12 : h % 12);
    e = bin ? 8'(x) : {4'(x / 10), 4'(x % 10)};
    e[7] = e[7] | (!h24 && h >= 12);
    return e;
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    resume_well_reset_n = 1'b1;
    rtc_well_reset_n = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    void'($urandom(94351));
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Readback, corners first, masked writes ignored
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      bus(1'b0, A_CFG, v, 4'h1);
      bus(1'b0, A_CFG, ~v, {3'($urandom), 1'b0});
      rd_chk(A_CFG, v);
    end
    bus(1'b0, 8'h3c, 8'h5a, 4'h1);
    rd_chk(8'h3c, 8'h00);
    // Resume well only, RTC well only, both together
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, A_CFG, 8'hff, 4'h1);
      pulse(k != 1, k != 0);
      rd_chk(A_CFG, exp_well(8'hff, k != 1, k != 0));
    end
    // Hour byte in every data and hour format
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, A_CFG, 8'h86, 4'h1);
      bus(1'b0, A_HOUR, 8'(hrs[i]), 4'h1);
      for (int f = 0; f < 4; f++) begin
        bus(1'b0, A_CFG, {5'h10, f[1], f[0], 1'b0}, 4'h1);
        rd_chk(A_HOUR, exp_hour(hrs[i], f[1], f[0]));
      end
    end
    // Synchronous reset leaves the configuration alone
    v = 8'($urandom) | 8'h80;
    bus(1'b0, A_CFG, v, 4'h1);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk(A_CFG, v);
    // Periodic events, enabled then masked, then rate zero
    bus(1'b0, A_RATE, 8'h06, 4'h1);
    bus(1'b0, A_CFG, 8'h40, 4'h1);
    wait_irq(200, 1'b0);
    check(hit, 1'b1);
    rd_chk(A_FLAG, 8'hc0);
    bus(1'b0, A_CFG, 8'h00, 4'h1);
    wait_irq(200, 1'b0);
    check(hit, 1'b0);
    rd_chk(A_FLAG, 8'h40);
    bus(1'b0, A_RATE, 8'h00, 4'h1);
    bus(1'b1, A_FLAG, 8'h00, 4'h1);
    repeat (200) @(posedge clk_sys);
    rd_chk(A_FLAG, 8'h00);
    // Updates into the April switch, alarm matching the third one
    bus(1'b0, A_CFG, 8'h86, 4'h1);
    bus(1'b0, A_MON, MON_APRIL, 4'h1);
    bus(1'b0, A_WDAY, SUNDAY, 4'h1);
    bus(1'b0, A_DATE, 8'h01 + 8'($urandom % 7), 4'h1);
    bus(1'b0, A_HOUR, DST_HOUR, 4'h1);
    bus(1'b0, A_MIN, 8'h3b, 4'h1);
    bus(1'b0, A_SEC, 8'h39, 4'h1);
    bus(1'b0, A_ASEC, 8'hc0, 4'h1);
    bus(1'b0, A_AHR, 8'h03, 4'h1);
    bus(1'b0, A_CFG, 8'h33, 4'h1);
    for (int n = 0; n < 3; n++) begin
      wait_irq(40000, 1'b0);
      check(hit, 1'b1);
      rd_chk(A_FLAG, (n == 2) ? 8'hb0 : 8'h90);
      rd_chk(A_SEC, (n == 2) ? 8'h00 : 8'(8'h58 + n));
    end
    rd_chk(A_HOUR, 8'h03);
    test_done();
  end
endmodule
bind rtcg_general_config rtcg_general_config_properties u_props (
  .clk_sys, .sys_rst, .resume_well_reset_n, .rtc_well_reset_n,
  .avs_address, .avs_read, .avs_write, .avs_byteenable,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .rtc_irq_out_n
);
